/* File: src/svs_map.svh */
/*
  Register offsets, field positions, reset values and allocation codes of the
  sequence I/O and safety gate block.
  Assumes it is included by bare name wherever these constants are used.
*/
`ifndef SVS_MAP_SVH
`define SVS_MAP_SVH

// Register byte addresses
`define SVS_ADDR_CTRL 8'h00
`define SVS_ADDR_IN_ALLOC 8'h04
`define SVS_ADDR_OUT_ALLOC 8'h08
`define SVS_ADDR_STATUS 8'h0c
`define SVS_ADDR_IRQ_STAT 8'h10
`define SVS_ADDR_IRQ_MASK 8'h14

// Control register
`define SVS_CTRL_SERVO_ON_BIT 0
`define SVS_CTRL_RST 1'h0

// Input allocation: one 4-bit code per function
`define SVS_IN_CODE_W 4
`define SVS_IN_FN_N 6
`define SVS_IN_PIN_N 7
`define SVS_CODE_ALWAYS_ON 4'h7
`define SVS_CODE_ALWAYS_OFF 4'h8
`define SVS_CODE_INV_BASE 4'h9
`define SVS_IN_ALLOC_RST 24'h654321

// Output allocation: 2-bit code per function, brake in bits [1:0]
`define SVS_OUT_CODE_W 2
`define SVS_OUT_BRAKE_RST 2'h1

// Status register fields
`define SVS_STS_PIN_LSB 0
`define SVS_STS_FN_LSB 8
`define SVS_STS_SAFE_LSB 16
`define SVS_STS_BB_BIT 18
`define SVS_STS_MON_BIT 19
`define SVS_STS_FAULT_BIT 20
`define SVS_STS_CUR_BIT 21

// Interrupt sources
`define SVS_IRQ_W 4
`define SVS_IRQ_FAULT 0
`define SVS_IRQ_FWD 1
`define SVS_IRQ_REV 2
`define SVS_IRQ_BB 3
`define SVS_IRQ_MASK_RST 4'h0

`endif

/* File: src/svs_pkg.sv */
/*
  Types of the sequence I/O and safety gate block.
  Assumes svs_map.svh is compiled alongside for the numeric constants.
*/
package svs_pkg;

  typedef logic [3:0] svs_in_code_t;

  // Output pin selected by an output allocation code
  typedef enum logic [1:0] {
    SVS_OUT_NONE,
    SVS_OUT_PIN1,
    SVS_OUT_PIN2,
    SVS_OUT_PIN3
  } svs_out_sel_t;

endpackage

/* File: src/svs_sync.sv */
/*
  Two-stage synchroniser for a vector of slow external levels.
  Assumes the levels change far slower than clk_sys_i; no bus coherency kept.
*/
`timescale 1ns/1ps
module svs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds the second stage only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

/* File: src/svs_io_safety.sv */
/*
  Sequence input/output allocation and hard-wired safety gate of a linear
  servo drive, with a small register port and one interrupt line.
  Assumes inputs are levels from the connector, the drive core supplies its
  fault flag, brake request and output functions synchronously to clk_sys_i.
*/
`timescale 1ns/1ps
`include "svs_map.svh"

// Summary of operation
// - Any detected fault turns fault output off
// - Brake output on releases, off holds brake
// - Brake pin reassignable to first general output
// - Travel limit input stops motion that direction
// - Either safety input off forces base block
// - Monitor on: both safety off, base block
// - Input function allocation set by configuration
// - Outputs two, three carry only assigned functions
// - Shared input pin drives all assigned functions
// - Codes 7, 8 force constant on, off
module svs_io_safety #(
  parameter int N_OUT_FN = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Connector sequence inputs
  input wire logic option_gp_input_0_i,
  input wire logic fwd_travel_limit_in_i,
  input wire logic rev_travel_limit_in_i,
  input wire logic option_input_3_i,
  input wire logic option_input_4_i,
  input wire logic option_input_5_i,
  input wire logic option_input_6_i,
  // Safety inputs, high means current permitted
  input wire logic safety_stop_in_1_i,
  input wire logic safety_stop_in_2_i,
  // Drive core
  input wire logic fault_detect_i,
  input wire logic brake_release_req_i,
  input wire logic [N_OUT_FN-1:0] out_fn_i,
  output logic fwd_stop_o,
  output logic rev_stop_o,
  output logic [3:0] opt_fn_o,
  output logic opt_gp0_o,
  output logic base_block_o,
  output logic motor_current_en_o,
  // Connector outputs
  output logic fault_out_o,
  output logic brake_release_out_o,
  output logic gp_output_2_o,
  output logic gp_output_3_o,
  output logic safe_state_monitor_out_o,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Interrupt
  output logic irq_o
);

  localparam int NF = N_OUT_FN + 1;
  localparam int CW = `SVS_IN_CODE_W;
  localparam int OW = `SVS_OUT_CODE_W;

  logic [`SVS_IN_PIN_N-1:0] pin_raw;
  logic [`SVS_IN_PIN_N-1:0] pin_s;
  logic [1:0] safe_s;
  logic [`SVS_IN_FN_N-1:0] fn_lvl;
  logic [NF-1:0] out_src;
  logic [2:0] pin_lvl;

  logic ctrl_q;
  logic [`SVS_IN_FN_N*CW-1:0] in_alloc_q;
  logic [NF*OW-1:0] out_alloc_q;
  logic [`SVS_IRQ_W-1:0] irq_sts_q;
  logic [`SVS_IRQ_W-1:0] irq_sts_d;
  logic [`SVS_IRQ_W-1:0] irq_mask_q;
  logic [`SVS_IRQ_W-1:0] irq_ev;
  logic [31:0] rdata_q;
  logic [31:0] status_w;

  logic fwd_stop_q;
  logic rev_stop_q;
  logic [3:0] opt_fn_q;
  logic opt_gp0_q;
  logic bb_q;
  logic cur_en_q;
  logic fault_out_q;
  logic fault_prev_q;
  logic mon_q;
  logic [2:0] pin_out_q;

  // Input level for one allocation code
  function automatic logic fn_level(input logic [CW-1:0] code,
                                    input logic [`SVS_IN_PIN_N-1:0] pins);
    logic lvl;
    lvl = 1'b0;
    if (code < `SVS_CODE_ALWAYS_ON) begin
      lvl = pins[code[2:0]];
    end else if (code == `SVS_CODE_ALWAYS_ON) begin
      lvl = 1'b1;
    end else if (code == `SVS_CODE_ALWAYS_OFF) begin
      lvl = 1'b0;
    end else begin
      lvl = ~pins[3'(code - `SVS_CODE_INV_BASE)];
    end
    return lvl;
  endfunction

  // OR of every output function allocated to one pin
  function automatic logic pin_drive(input logic [NF*OW-1:0] alloc,
                                     input logic [NF-1:0] src,
                                     input svs_pkg::svs_out_sel_t sel);
    logic lvl;
    lvl = 1'b0;
    for (int k = 0; k < NF; k++) begin
      if (alloc[k*OW +: OW] == sel) begin
        lvl = lvl | src[k];
      end
    end
    return lvl;
  endfunction

  // Pin order is the allocation code order: code 0 is the general input
  assign pin_raw = {option_input_6_i, option_input_5_i, option_input_4_i,
                    option_input_3_i, rev_travel_limit_in_i,
                    fwd_travel_limit_in_i, option_gp_input_0_i};

  svs_sync #(.W(`SVS_IN_PIN_N + 2)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({safety_stop_in_2_i, safety_stop_in_1_i, pin_raw}),
    .sync_o({safe_s, pin_s})
  );

  // Each function reads its own code, so a shared pin reaches all of them
  genvar gf;
  generate
    for (gf = 0; gf < `SVS_IN_FN_N; gf++) begin : g_in_fn
      assign fn_lvl[gf] = fn_level(in_alloc_q[gf*CW +: CW], pin_s);
    end
  endgenerate

  assign out_src = {out_fn_i, brake_release_req_i};

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_out_pin
      assign pin_lvl[gp] = pin_drive(out_alloc_q, out_src,
                                     svs_pkg::svs_out_sel_t'(gp + 1));
    end
  endgenerate

  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ctrl_q <= `SVS_CTRL_RST;
      in_alloc_q <= `SVS_IN_ALLOC_RST;
      out_alloc_q <= {{(NF-1)*OW{1'b0}}, `SVS_OUT_BRAKE_RST};
      irq_mask_q <= `SVS_IRQ_MASK_RST;
    end else if (wr_i) begin
      case (addr_i)
        `SVS_ADDR_CTRL: ctrl_q <= wdata_i[`SVS_CTRL_SERVO_ON_BIT];
        `SVS_ADDR_IN_ALLOC: in_alloc_q <= wdata_i[`SVS_IN_FN_N*CW-1:0];
        `SVS_ADDR_OUT_ALLOC: out_alloc_q <= wdata_i[NF*OW-1:0];
        `SVS_ADDR_IRQ_MASK: irq_mask_q <= wdata_i[`SVS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Travel limits and option functions
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fwd_stop_q <= 1'b0;
      rev_stop_q <= 1'b0;
      opt_fn_q <= 4'h0;
      opt_gp0_q <= 1'b0;
    end else begin
      fwd_stop_q <= fn_lvl[0];
      rev_stop_q <= fn_lvl[1];
      opt_fn_q <= fn_lvl[5:2];
      opt_gp0_q <= pin_s[0];
    end
  end

  // Safety gate; base block held in reset so current never flows early
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      bb_q <= 1'b1;
      mon_q <= 1'b0;
      cur_en_q <= 1'b0;
    end else begin
      bb_q <= ~(safe_s[0] & safe_s[1]);
      mon_q <= bb_q & ~safe_s[0] & ~safe_s[1];
      // Both synced channels must be on; a single stopped channel removes current
      cur_en_q <= ctrl_q & ~bb_q & safe_s[0] & safe_s[1] & fault_out_q;
    end
  end

  // Fault and general outputs; fault shows active while reset is held
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fault_out_q <= 1'b0;
      fault_prev_q <= 1'b0;
      pin_out_q <= 3'h0;
    end else begin
      fault_out_q <= ~fault_detect_i;
      fault_prev_q <= fault_detect_i;
      pin_out_q <= pin_lvl;
    end
  end

  // Interrupt events; a new event wins over a clear in the same cycle
  assign irq_ev[`SVS_IRQ_FAULT] = fault_detect_i & ~fault_prev_q;
  assign irq_ev[`SVS_IRQ_FWD] = fn_lvl[0] & ~fwd_stop_q;
  assign irq_ev[`SVS_IRQ_REV] = fn_lvl[1] & ~rev_stop_q;
  assign irq_ev[`SVS_IRQ_BB] = ~(safe_s[0] & safe_s[1]) & ~bb_q;

  always_comb begin
    irq_sts_d = irq_sts_q;
    if (wr_i && addr_i == `SVS_ADDR_IRQ_STAT) begin
      irq_sts_d = irq_sts_d & ~wdata_i[`SVS_IRQ_W-1:0];
    end
    irq_sts_d = irq_sts_d | irq_ev;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= irq_sts_d;
    end
  end

  // Status view of the block's own state
  always_comb begin
    status_w = 32'h0;
    status_w[`SVS_STS_PIN_LSB +: `SVS_IN_PIN_N] = pin_s;
    status_w[`SVS_STS_FN_LSB +: `SVS_IN_FN_N] = fn_lvl;
    status_w[`SVS_STS_SAFE_LSB +: 2] = safe_s;
    status_w[`SVS_STS_BB_BIT] = bb_q;
    status_w[`SVS_STS_MON_BIT] = mon_q;
    status_w[`SVS_STS_FAULT_BIT] = fault_out_q;
    status_w[`SVS_STS_CUR_BIT] = cur_en_q;
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        `SVS_ADDR_CTRL: rdata_q <= {31'h0, ctrl_q};
        `SVS_ADDR_IN_ALLOC: rdata_q <= {{(32-`SVS_IN_FN_N*CW){1'b0}}, in_alloc_q};
        `SVS_ADDR_OUT_ALLOC: rdata_q <= {{(32-NF*OW){1'b0}}, out_alloc_q};
        `SVS_ADDR_STATUS: rdata_q <= status_w;
        `SVS_ADDR_IRQ_STAT: rdata_q <= {{(32-`SVS_IRQ_W){1'b0}}, irq_sts_q};
        `SVS_ADDR_IRQ_MASK: rdata_q <= {{(32-`SVS_IRQ_W){1'b0}}, irq_mask_q};
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign fwd_stop_o = fwd_stop_q;
  assign rev_stop_o = rev_stop_q;
  assign opt_fn_o = opt_fn_q;
  assign opt_gp0_o = opt_gp0_q;
  assign base_block_o = bb_q;
  assign motor_current_en_o = cur_en_q;
  assign fault_out_o = fault_out_q;
  assign brake_release_out_o = pin_out_q[0];
  assign gp_output_2_o = pin_out_q[1];
  assign gp_output_3_o = pin_out_q[2];
  assign safe_state_monitor_out_o = mon_q;
  assign rdata_o = rdata_q;
  assign irq_o = |(irq_sts_q & irq_mask_q);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_fault_off;
    fault_detect_i |=> !fault_out_o;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault output not off after fault");

  property p_brake_release;
    (out_alloc_q[OW-1:0] == `SVS_OUT_BRAKE_RST) && brake_release_req_i |=> brake_release_out_o;
  endproperty
  a_brake_release: assert property (p_brake_release)
    else $error("brake not released on request");

  property p_brake_reassign;
    (out_alloc_q[OW-1:0] != `SVS_OUT_BRAKE_RST) && !pin_lvl[0] |=> !brake_release_out_o;
  endproperty
  a_brake_reassign: assert property (p_brake_reassign)
    else $error("brake pin driven though unassigned");

  property p_fwd_stop;
    fn_lvl[0] |=> fwd_stop_o;
  endproperty
  a_fwd_stop: assert property (p_fwd_stop)
    else $error("forward limit did not stop motion");

  property p_safety_bb;
    !(safe_s[0] && safe_s[1]) |=> base_block_o && !motor_current_en_o;
  endproperty
  a_safety_bb: assert property (p_safety_bb)
    else $error("safety input off without base block");

  sequence s_both_off;
    !safe_s[0] && !safe_s[1];
  endsequence

  sequence s_bb_reached;
    s_both_off ##1 (s_both_off and base_block_o);
  endsequence

  property p_mon_on;
    s_bb_reached |=> safe_state_monitor_out_o;
  endproperty
  a_mon_on: assert property (p_mon_on)
    else $error("monitor not on in safe state");

  property p_mon_only;
    safe_state_monitor_out_o |-> $past(base_block_o) && !$past(safe_s[0]) && !$past(safe_s[1]);
  endproperty
  a_mon_only: assert property (p_mon_only)
    else $error("monitor on outside safe state");

  property p_gp2_unassigned;
    !pin_lvl[1] |=> !gp_output_2_o;
  endproperty
  a_gp2_unassigned: assert property (p_gp2_unassigned)
    else $error("output two driven without function");

  property p_shared_pin;
    in_alloc_q[CW-1:0] == in_alloc_q[2*CW-1:CW] |-> fn_lvl[0] == fn_lvl[1];
  endproperty
  a_shared_pin: assert property (p_shared_pin)
    else $error("shared pin gave differing levels");

  property p_const_codes;
    (in_alloc_q[CW-1:0] == `SVS_CODE_ALWAYS_ON |=> fwd_stop_o) and
    (in_alloc_q[CW-1:0] == `SVS_CODE_ALWAYS_OFF |=> !fwd_stop_o);
  endproperty
  a_const_codes: assert property (p_const_codes)
    else $error("constant code not applied");

  sequence s_raw_off;
    !safety_stop_in_1_i [*3];
  endsequence

  property p_sync_latency;
    s_raw_off |=> base_block_o;
  endproperty
  a_sync_latency: assert property (p_sync_latency)
    else $error("safety input not through two stages");

endmodule

/* File: verification/svs_host_model.sv */
/*
  Host controller and external safety device model: drives the connector levels.
  Assumes the bench changes its commands just after a rising clock edge.
*/
`timescale 1ns/1ps
module svs_host_model (
  // Commands from the bench
  input wire logic [6:0] pin_cmd_i,
  input wire logic [1:0] safe_cmd_i,
  // Connector levels
  output logic [6:0] pins_o,
  output logic safety_stop_in_1_o,
  output logic safety_stop_in_2_o
);
  // Safety device wired to release both channels unless a stop is commanded
  assign safety_stop_in_1_o = safe_cmd_i[0];
  assign safety_stop_in_2_o = safe_cmd_i[1];
  assign pins_o = pin_cmd_i;
endmodule

/* File: verification/svs_io_safety_tb.sv */
/*
  Self-checking bench of the sequence I/O and safety gate block.
  Assumes a 40 MHz clock and the register map of svs_map.svh.
*/
`timescale 1ns/1ps
`include "svs_map.svh"
module svs_io_safety_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [6:0] pin_cmd = 7'h00;
  logic [1:0] safe_cmd = 2'h3;
  logic [6:0] pins;
  logic saf1, saf2;
  logic fault_detect_i = 1'b0;
  logic brake_release_req_i = 1'b0;
  logic [7:0] out_fn_i = 8'h00;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, rv;
  logic fwd_stop_o, rev_stop_o, opt_gp0_o, base_block_o, motor_current_en_o;
  logic [3:0] opt_fn_o;
  logic fault_out_o, brake_release_out_o, gp_output_2_o, gp_output_3_o, safe_state_monitor_out_o, irq_o;
  int errors = 0;
  int checked = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  svs_host_model i_host (.pin_cmd_i(pin_cmd), .safe_cmd_i(safe_cmd), .pins_o(pins),
    .safety_stop_in_1_o(saf1), .safety_stop_in_2_o(saf2));

  svs_io_safety #(.N_OUT_FN(8)) i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .option_gp_input_0_i(pins[0]), .fwd_travel_limit_in_i(pins[1]), .rev_travel_limit_in_i(pins[2]),
    .option_input_3_i(pins[3]), .option_input_4_i(pins[4]), .option_input_5_i(pins[5]),
    .option_input_6_i(pins[6]), .safety_stop_in_1_i(saf1), .safety_stop_in_2_i(saf2),
    .fault_detect_i(fault_detect_i), .brake_release_req_i(brake_release_req_i), .out_fn_i(out_fn_i),
    .fwd_stop_o(fwd_stop_o), .rev_stop_o(rev_stop_o), .opt_fn_o(opt_fn_o), .opt_gp0_o(opt_gp0_o),
    .base_block_o(base_block_o), .motor_current_en_o(motor_current_en_o), .fault_out_o(fault_out_o),
    .brake_release_out_o(brake_release_out_o), .gp_output_2_o(gp_output_2_o),
    .gp_output_3_o(gp_output_3_o), .safe_state_monitor_out_o(safe_state_monitor_out_o),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic t_regs();
    rd(`SVS_ADDR_IN_ALLOC, rv);
    check("in_alloc", rv, 32'h00654321);
    rd(`SVS_ADDR_OUT_ALLOC, rv);
    check("out_alloc", rv, 32'h00000001);
    rd(`SVS_ADDR_IRQ_MASK, rv);
    check("irq_mask", rv, 32'h0);
    rd(8'h20, rv);
    check("unmapped", rv, 32'h0);
  endtask

  task automatic t_fault();
    check("no_fault", fault_out_o, 1);
    @(posedge clk_sys_i);
    fault_detect_i <= 1'b1;
    tick(1);
    check("fault_out", fault_out_o, 0);
    wr(`SVS_ADDR_IRQ_MASK, 32'h1);
    tick(1);
    check("irq_on", irq_o, 1);
    fault_detect_i <= 1'b0;
    tick(1);
    check("fault_gone", fault_out_o, 1);
    wr(`SVS_ADDR_IRQ_STAT, 32'hf);
    tick(1);
    check("irq_clr", irq_o, 0);
  endtask

  task automatic t_outputs();
    @(posedge clk_sys_i);
    brake_release_req_i <= 1'b1;
    tick(1);
    check("brake_rel", brake_release_out_o, 1);
    brake_release_req_i <= 1'b0;
    tick(1);
    check("brake_hold", brake_release_out_o, 0);
    // First output function moved onto the brake pin, brake unassigned
    wr(`SVS_ADDR_OUT_ALLOC, 32'h4);
    brake_release_req_i <= 1'b1;
    out_fn_i <= 8'h01;
    tick(2);
    check("pin1_fn1", brake_release_out_o, 1);
    out_fn_i <= 8'h00;
    tick(1);
    check("pin1_nobrk", brake_release_out_o, 0);
    out_fn_i <= 8'hff;
    tick(1);
    check("gp2_unasg", gp_output_2_o, 0);
    check("gp3_unasg", gp_output_3_o, 0);
    wr(`SVS_ADDR_OUT_ALLOC, 32'he0);
    tick(2);
    check("gp2_asg", gp_output_2_o, 1);
    check("gp3_asg", gp_output_3_o, 1);
    out_fn_i <= 8'hfd;
    tick(1);
    check("gp2_fn", gp_output_2_o, 0);
    wr(`SVS_ADDR_OUT_ALLOC, 32'h1);
    brake_release_req_i <= 1'b0;
    out_fn_i <= 8'h00;
  endtask

  task automatic t_limits();
    logic [3:0] codes [3] = '{4'h7, 4'h8, 4'ha};
    logic [6:0] pv [3] = '{7'h00, 7'h7f, 7'h7d};
    logic [31:0] ex [3] = '{1, 0, 1};
    for (int c = 0; c < 7; c++) begin
      wr(`SVS_ADDR_IN_ALLOC, {8'h00, 20'h65432, c[3:0]});
      pin_cmd <= 7'h01 << c;
      tick(2);
      check("fwd_sync", fwd_stop_o, 0);
      tick(1);
      check("fwd_pin", fwd_stop_o, 1);
      check("gp0_pin", opt_gp0_o, c == 0);
      pin_cmd <= 7'h00;
      tick(3);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`SVS_ADDR_IN_ALLOC, {8'h00, 20'h65432, codes[i]});
      pin_cmd <= pv[i];
      tick(4);
      check("fwd_code", fwd_stop_o, ex[i]);
    end
    wr(`SVS_ADDR_IN_ALLOC, 32'h00654311);
    pin_cmd <= 7'h02;
    tick(4);
    check("shared_fwd", fwd_stop_o, 1);
    check("shared_rev", rev_stop_o, 1);
    wr(`SVS_ADDR_IN_ALLOC, 32'h00654321);
    pin_cmd <= 7'h7c;
    tick(4);
    check("rev_stop", rev_stop_o, 1);
    check("fwd_clear", fwd_stop_o, 0);
    check("opt_fn", opt_fn_o, 4'hf);
    pin_cmd <= 7'h00;
    tick(3);
  endtask

  task automatic t_safety();
    wr(`SVS_ADDR_CTRL, 32'h1);
    rd(`SVS_ADDR_CTRL, rv);
    check("ctrl", rv, 32'h1);
    tick(5);
    check("cur_on", motor_current_en_o, 1);
    safe_cmd <= 2'h2;
    tick(2);
    check("bb_sync", base_block_o, 0);
    tick(1);
    check("bb_one", base_block_o, 1);
    tick(2);
    check("cur_off", motor_current_en_o, 0);
    check("mon_one", safe_state_monitor_out_o, 0);
    rd(`SVS_ADDR_IRQ_STAT, rv);
    check("bb_event", rv & 32'h8, 32'h8);
    safe_cmd <= 2'h0;
    tick(5);
    check("mon_both", safe_state_monitor_out_o, 1);
    // Base block, monitor and no-fault set; pins, functions, safety and current low
    rd(`SVS_ADDR_STATUS, rv);
    check("status_safe", rv, 32'h001c0000);
    safe_cmd <= 2'h1;
    tick(5);
    check("bb_two", base_block_o, 1);
    check("mon_gone", safe_state_monitor_out_o, 0);
    safe_cmd <= 2'h3;
    tick(6);
    check("bb_free", base_block_o, 0);
    check("cur_back", motor_current_en_o, 1);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    #1;
    check("bb_rst", base_block_o, 1);
    check("fault_rst", fault_out_o, 0);
    rst_b_i <= 1'b1;
    tick(4);
    t_regs();
    t_fault();
    t_outputs();
    t_limits();
    t_safety();
    final_report();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #500000;
    errors++;
    final_report();
  end
endmodule
